/* core/blk_prot_pkg.sv */
/*
 * package for the block protection and general input register logic:
 * block numbering, lock register layout, reset values, the read-lock byte,
 * the general input width and the status error bit position.
 * assumes the bus cycle decoder outside hands over byte-wide register
 * and array accesses already split into block number and select flags.
 */
package blk_prot_pkg;

    // block geometry
    localparam int unsigned NUM_BLOCKS = 50;
    localparam int unsigned BLK_W = 6;
    localparam logic [5:0] TOP_BLOCK = 6'h31;         // block 49
    localparam logic [5:0] LAST_SHARED_BLOCK = 6'h0F; // blocks 0..15 share
    localparam logic [5:0] FIRST_OWN_BLOCK = 6'h10;   // block 16
    // one lock register for blocks 0..15 plus one each for 16..49
    localparam int unsigned NUM_LOCK_REGS = 35;
    localparam int unsigned LREG_W = 6;

    // lock register field positions
    localparam int unsigned WRITE_LOCK_BIT = 0;
    localparam int unsigned LOCK_DOWN_BIT = 1;
    localparam int unsigned READ_LOCK_BIT = 2;
    localparam int unsigned LOCK_FIELD_W = 3;

    // reset value: write locked, readable, not locked down
    localparam logic [2:0] LOCK_RESET = 3'h1;
    // byte returned for read-locked blocks
    localparam logic [7:0] READ_LOCK_DATA = 8'h00;

    // general input register layout
    localparam int unsigned GPI_W = 5;

    // status register bit for block protection errors
    localparam int unsigned STATUS_BLK_PROT_BIT = 1;

endpackage : blk_prot_pkg

/* core/pin_sync.sv */
/*
 * two-stage synchroniser for a bus of pin inputs.
 * assumes each bit is an independent slow level; no bus coherency.
 */
`timescale 1ns/100ps

module pin_sync #(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] level_o
);

    logic [WIDTH-1:0] meta_r; // first stage, read only by second stage
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] level_r;
    logic [WIDTH-1:0] level_nxt;

    // next values: plain shift
    always_comb
    begin
        meta_nxt = pin_i;
        level_nxt = meta_r;
    end

    // register both stages
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            meta_r <= INIT;
            level_r <= INIT;
        end
        else
        begin
            meta_r <= meta_nxt;
            level_r <= level_nxt;
        end
    end

    assign level_o = level_r;

endmodule : pin_sync

/* core/flash_block_lock.sv */
/*
 * lock registers, protection decision and general input register of a
 * boot flash on the low pin count bus.
 * assumes the bus decoder hands over one-cycle register strobes with a
 * lock register index, and one-cycle array request strobes with a
 * block number; the array and command engine sit outside.
 * the lock bits and the status bit are the only state here that software can change;
 * program and erase are only allowed or refused, never carried out.
 * every answer appears one clock after its strobe.
 */
`timescale 1ns/100ps

// What this block does
// R1 - read-locked block reads return 00h
// R2 - lock-down set ignores lock register writes
// R3 - lock-down sticky until reset or power-up
// R4 - write-locked block refuses program, flags error
// R5 - unlocked block program and erase proceed
// R6 - own lock register per block, 0-15 shared
// R7 - voltage lockout protects every block
// R8 - top block protect low refuses block 49
// R9 - write protect low refuses blocks 0-48
// R10 - reset sets every write lock bit
// R11 - reset clears every read lock bit
// R12 - input register shows five input levels
// R13 - lock reserved bits read zero, ignore writes
// R14 - input register read-only, writes ignored
// R15 - protected attempt sets sticky status bit
// R16 - registers reachable only in bus interface mode
module flash_block_lock (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic init_n_i,          // initialise pin, low resets locks
    input wire logic lpc_mode_i,        // low pin count interface selected
    // register access from the bus decoder
    input wire logic lock_sel_i,        // access hits a lock register
    input wire logic gpi_sel_i,         // access hits the input register
    input wire logic [5:0] lock_idx_i,  // lock register index, 0 = shared
    input wire logic reg_wr_i,          // one-cycle write strobe
    input wire logic reg_rd_i,          // one-cycle read strobe
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // array read path
    input wire logic arr_rd_i,          // one-cycle array read strobe
    input wire logic [5:0] arr_rd_blk_i,
    input wire logic [7:0] arr_rdata_i, // stored byte from the array
    output logic [7:0] arr_rdata_o,
    output logic arr_rvalid_o,
    // program and block erase requests
    input wire logic mod_req_i,         // one-cycle program or erase
    input wire logic [5:0] mod_blk_i,
    output logic mod_go_o,              // pulse: array may be changed
    output logic mod_refused_o,         // pulse: attempt was blocked
    input wire logic status_clr_i,      // clear status register command
    output logic blk_prot_status_o,     // sticky protection error bit
    // pins from outside the clock domain
    input wire logic top_block_protect_n_i,
    input wire logic write_protect_n_i,
    input wire logic program_voltage_lockout_i,
    input wire logic [4:0] general_input_i
);

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers

    // three protect pins above the five general inputs
    localparam int unsigned PIN_W = 3 + blk_prot_pkg::GPI_W;

    logic [PIN_W-1:0] pins_raw;
    logic [PIN_W-1:0] pins_s;        // synchronised pin levels
    logic tbp_n_s;
    logic wp_n_s;
    logic vplk_s;
    logic [4:0] gpi_s;

    assign pins_raw = {top_block_protect_n_i, write_protect_n_i,
                       program_voltage_lockout_i, general_input_i};

    // sync reset levels: top and write protect low, lockout high,
    // inputs low; until real samples arrive every block is protected
    localparam logic [2:0] PROT_PINS_SAFE = 3'h1;
    localparam logic [4:0] GPI_IDLE = 5'h00;

    // protect pins start at their safe (protecting) level
    pin_sync #(
        .WIDTH(PIN_W),
        .INIT({PROT_PINS_SAFE, GPI_IDLE})
    ) u_pin_sync (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .pin_i(pins_raw),
        .level_o(pins_s)
    );

    // split the synchronised word back into its pins
    assign tbp_n_s = pins_s[PIN_W-1];
    assign wp_n_s = pins_s[PIN_W-2];
    assign vplk_s = pins_s[PIN_W-3];
    assign gpi_s = pins_s[blk_prot_pkg::GPI_W-1:0];

    // initialise pin is a pin too; sync before use
    // it clears two edges late, which is harmless: the pin is slow and
    // the clear holds for as long as the pin stays low
    localparam logic [1:0] INIT_SYNC_IDLE = 2'h3; // released level
    logic [1:0] init_sync_r;
    logic [1:0] init_sync_nxt;
    logic init_n_s;

    // shift the pin into the two stages
    always_comb
    begin
        init_sync_nxt = {init_sync_r[0], init_n_i};
    end

    // only the second stage is read by the lock and status logic
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            init_sync_r <= INIT_SYNC_IDLE;
        else
            init_sync_r <= init_sync_nxt;
    end

    assign init_n_s = init_sync_r[1];

    ////////////////////////////////////////////////////////////////////
    // lock register file

    // short names for the register count and the lock fields
    localparam int unsigned NL = blk_prot_pkg::NUM_LOCK_REGS;
    localparam int unsigned WL = blk_prot_pkg::WRITE_LOCK_BIT;
    localparam int unsigned LD = blk_prot_pkg::LOCK_DOWN_BIT;
    localparam int unsigned RL = blk_prot_pkg::READ_LOCK_BIT;

    // the register file is flops, one word per lock register
    logic [2:0] lock_r [NL];    // write lock, lock down, read lock
    logic [2:0] lock_nxt [NL];
    logic lock_wr_ok;           // write reaches the lock registers
    logic idx_ok;               // index within the register file

    // writes outside the interface mode or the file are dropped
    assign idx_ok = lock_idx_i < 6'(NL);
    assign lock_wr_ok = reg_wr_i && lock_sel_i && lpc_mode_i && idx_ok; // R16

    // one next-state term per lock register
    generate
        for (genvar g = 0; g < NL; g++)
        begin : g_lock
            always_comb
            begin
                // default: hold the stored bits
                lock_nxt[g] = lock_r[g];
                // an initialise beats any write in the same cycle
                if (!init_n_s)
                    lock_nxt[g] = blk_prot_pkg::LOCK_RESET; // R3 R10 R11
                else if (lock_wr_ok && lock_idx_i == 6'(g)
                         && !lock_r[g][LD]) // R2
                    lock_nxt[g] = reg_wdata_i[2:0]; // R13
                // locked down: nothing but a clear gets through
                else if (lock_r[g][LD])
                    lock_nxt[g] = lock_r[g]; // R3
            end

            // reset loads write locked, readable, unlocked-down
            always_ff @(posedge clk_sys_i or posedge rst_i)
            begin
                if (rst_i)
                    lock_r[g] <= blk_prot_pkg::LOCK_RESET; // R10 R11
                else
                    lock_r[g] <= lock_nxt[g];
            end
        end
    endgenerate

    // block number to lock register index; blocks 0..15 share index 0
    // blocks above the top give an index out of range; the callers
    // only use the index behind a range check
    function automatic logic [5:0] blk_to_idx(input logic [5:0] blk);
        logic [5:0] idx;
        idx = 6'h00;
        if (blk > blk_prot_pkg::LAST_SHARED_BLOCK)
            idx = blk - blk_prot_pkg::LAST_SHARED_BLOCK; // R6
        return idx;
    endfunction : blk_to_idx

    ////////////////////////////////////////////////////////////////////
    // protection decision and register reads

    // lock register indices of the two requests
    logic [5:0] mod_idx;
    logic [5:0] rd_idx;
    logic mod_blocked;
    logic mod_blk_ok;
    logic rd_locked;

    // both request paths share one block to register mapping
    assign mod_idx = blk_to_idx(mod_blk_i);
    assign rd_idx = blk_to_idx(arr_rd_blk_i);
    assign mod_blk_ok = mod_blk_i <= blk_prot_pkg::TOP_BLOCK;
    // read lock only for real blocks; others pass the array byte
    assign rd_locked = (arr_rd_blk_i <= blk_prot_pkg::TOP_BLOCK)
                       && lock_r[rd_idx][RL];

    // any one source is enough to block a program or erase
    // out-of-range blocks are refused too, never passed to the array
    always_comb
    begin
        mod_blocked = !mod_blk_ok;
        if (mod_blk_ok && lock_r[mod_idx][WL])
            mod_blocked = 1'b1; // R4
        // pin sources act whatever the lock bits say
        if (vplk_s)
            mod_blocked = 1'b1; // R7
        if (!tbp_n_s && mod_blk_i == blk_prot_pkg::TOP_BLOCK)
            mod_blocked = 1'b1; // R8
        if (!wp_n_s && mod_blk_i < blk_prot_pkg::TOP_BLOCK)
            mod_blocked = 1'b1; // R9
    end

    // answer and status flops with their next values
    logic mod_go_r;
    logic mod_go_nxt;
    logic mod_ref_r;
    logic mod_ref_nxt;
    logic status_r;
    logic status_nxt;
    logic [7:0] arr_rdata_r;
    logic [7:0] arr_rdata_nxt;
    logic arr_rvalid_r;
    logic arr_rvalid_nxt;
    logic [7:0] reg_rdata_r;
    logic [7:0] reg_rdata_nxt;
    logic reg_rvalid_r;
    logic reg_rvalid_nxt;

    // next values of the answer and status flops
    always_comb
    begin
        // exactly one of go and refused answers each request
        mod_go_nxt = mod_req_i && !mod_blocked; // R5
        mod_ref_nxt = mod_req_i && mod_blocked; // R4
        // set wins over a clear in the same cycle
        // so an attempt made while clearing is never lost
        status_nxt = status_r;
        if (status_clr_i || !init_n_s)
            status_nxt = 1'b0;
        if (mod_req_i && mod_blocked)
            status_nxt = 1'b1; // R15
        // array read: zeros for a read-locked block
        // the stored byte never leaves for a read-locked block
        arr_rvalid_nxt = arr_rd_i;
        arr_rdata_nxt = arr_rdata_i;
        if (rd_locked)
            arr_rdata_nxt = blk_prot_pkg::READ_LOCK_DATA; // R1
        // register read; unmapped or wrong mode reads zero
        reg_rvalid_nxt = reg_rd_i;
        reg_rdata_nxt = 8'h00;
        if (reg_rd_i && lpc_mode_i) // R16
        begin
            if (lock_sel_i && idx_ok)
                reg_rdata_nxt = {5'h00, lock_r[lock_idx_i]}; // R13
            // input register: live synchronised levels
            else if (gpi_sel_i)
                reg_rdata_nxt = {3'h0, gpi_s}; // R12 R14
        end
    end

    // register the answers; the input register has no write path
    // go, refused, valids and register data are pulses; array data tracks the array byte; only the status bit is sticky
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            mod_go_r <= 1'b0;
            mod_ref_r <= 1'b0;
            status_r <= 1'b0;
            arr_rdata_r <= 8'h00;
            arr_rvalid_r <= 1'b0;
            reg_rdata_r <= 8'h00;
            reg_rvalid_r <= 1'b0;
        end
        else
        begin
            mod_go_r <= mod_go_nxt;
            mod_ref_r <= mod_ref_nxt;
            status_r <= status_nxt;
            arr_rdata_r <= arr_rdata_nxt;
            arr_rvalid_r <= arr_rvalid_nxt;
            reg_rdata_r <= reg_rdata_nxt;
            reg_rvalid_r <= reg_rvalid_nxt;
        end
    end

    // every output comes straight from a flop
    assign mod_go_o = mod_go_r;
    assign mod_refused_o = mod_ref_r;
    assign blk_prot_status_o = status_r;
    assign arr_rdata_o = arr_rdata_r;
    assign arr_rvalid_o = arr_rvalid_r;
    assign reg_rdata_o = reg_rdata_r;
    assign reg_rvalid_o = reg_rvalid_r;

endmodule : flash_block_lock

/* testbench/blk_lock_sva.sv */
/* checker for flash_block_lock: bus answers, reserved bits, protect pins.
   assumes it is bound to flash_block_lock and sees its ports only. */
`timescale 1ns/100ps
module blk_lock_sva (
    input logic clk_sys_i,
    input logic rst_i,
    input logic init_n_i,
    input logic lock_sel_i,
    input logic gpi_sel_i,
    input logic reg_rd_i,
    input logic [7:0] reg_rdata_o,
    input logic reg_rvalid_o,
    input logic arr_rd_i,
    input logic arr_rvalid_o,
    input logic mod_req_i,
    input logic [5:0] mod_blk_i,
    input logic mod_go_o,
    input logic mod_refused_o,
    input logic status_clr_i,
    input logic blk_prot_status_o,
    input logic top_block_protect_n_i,
    input logic write_protect_n_i,
    input logic program_voltage_lockout_i
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////
    // pins held three edges so both sync stages carry the level
    sequence s_vl; program_voltage_lockout_i [*3]; endsequence
    sequence s_tb; !top_block_protect_n_i [*3]; endsequence
    sequence s_wp; !write_protect_n_i [*3]; endsequence
    sequence s_in; init_n_i [*3]; endsequence
    property p_rvalid; reg_rd_i |=> reg_rvalid_o; endproperty
    property p_rsv;
        reg_rvalid_o && $past(lock_sel_i) |-> reg_rdata_o[7:3] == 5'h00;
    endproperty
    property p_grsv;
        reg_rvalid_o && $past(gpi_sel_i) |-> reg_rdata_o[7:5] == 3'h0;
    endproperty
    property p_arr; arr_rd_i |=> arr_rvalid_o; endproperty
    property p_one; mod_req_i |=> mod_go_o ^ mod_refused_o; endproperty
    property p_vl; s_vl ##0 mod_req_i |=> mod_refused_o; endproperty
    property p_tb;
        s_tb ##0 (mod_req_i && mod_blk_i == 6'h31) |=> mod_refused_o;
    endproperty
    property p_wp;
        s_wp ##0 (mod_req_i && mod_blk_i < 6'h31) |=> mod_refused_o;
    endproperty
    // a clear or an initialise are the only ways out
    property p_stk;
        s_in ##0 (blk_prot_status_o && !status_clr_i) |=> blk_prot_status_o;
    endproperty
    a_rvalid: assert property (p_rvalid) else $error("no read answer");
    a_rsv: assert property (p_rsv) else $error("lock reserved set");
    a_grsv: assert property (p_grsv) else $error("input rsv set");
    a_arr: assert property (p_arr) else $error("no array answer");
    a_one: assert property (p_one) else $error("bad mod answer");
    a_vl: assert property (p_vl) else $error("lockout ignored");
    a_tb: assert property (p_tb) else $error("top pin ignored");
    a_wp: assert property (p_wp) else $error("wp pin ignored");
    a_stk: assert property (p_stk) else $error("status lost");
endmodule : blk_lock_sva
bind flash_block_lock blk_lock_sva u_sva (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .init_n_i(init_n_i),
    .lock_sel_i(lock_sel_i),
    .gpi_sel_i(gpi_sel_i),
    .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o),
    .arr_rd_i(arr_rd_i),
    .arr_rvalid_o(arr_rvalid_o),
    .mod_req_i(mod_req_i),
    .mod_blk_i(mod_blk_i),
    .mod_go_o(mod_go_o),
    .mod_refused_o(mod_refused_o),
    .status_clr_i(status_clr_i),
    .blk_prot_status_o(blk_prot_status_o),
    .top_block_protect_n_i(top_block_protect_n_i),
    .write_protect_n_i(write_protect_n_i),
    .program_voltage_lockout_i(program_voltage_lockout_i)
);

/* testbench/lpc_host_model.sv */
/* host side register master: one byte access per call.
   assumes strobes are sampled on the rising edge by the block. */
`timescale 1ns/100ps
module lpc_host_model (
    input logic clk_sys_i,
    output logic wr_o,
    output logic rd_o,
    output logic lock_o,
    output logic gpi_o,
    output logic [5:0] idx_o,
    output logic [7:0] wdata_o
);
    // idle bus at time zero
    initial
    begin
        {wr_o, rd_o, lock_o, gpi_o} = 4'h0;
        idx_o = 6'h00;
        wdata_o = 8'h00;
    end
    // one-cycle strobe; released data shows its inverse, not a stale copy
    task xfer(input logic w, input logic g, input logic [5:0] i,
              input logic [7:0] d);
        @(posedge clk_sys_i);
        wr_o <= w;
        rd_o <= !w;
        lock_o <= !g;
        gpi_o <= g;
        idx_o <= i;
        wdata_o <= d;
        @(posedge clk_sys_i);
        {wr_o, rd_o} <= 2'h0;
        wdata_o <= ~d;
    endtask : xfer
endmodule : lpc_host_model

/* testbench/flash_block_lock_tb.sv */
/* self-checking bench for flash_block_lock with a host model.
   assumes a 25 MHz clock and the one-cycle answers of the block. */
`timescale 1ns/100ps
module flash_block_lock_tb;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic init_n_i = 1'b1, lpc_mode_i = 1'b1, status_clr_i = 1'b0;
    logic wr, rd, lsel, gsel, arr_rd_i = 1'b0, mod_req_i = 1'b0;
    logic [5:0] idx, arr_rd_blk_i = 6'h00, mod_blk_i = 6'h00;
    logic [7:0] wdata, arr_rdata_i = 8'h00, reg_rdata_o, arr_rdata_o;
    logic reg_rvalid_o, arr_rvalid_o, mod_go_o, mod_refused_o, st;
    logic top_block_protect_n = 1'b1, wp = 1'b1, vl = 1'b0;
    logic [4:0] gpi = 5'h16;
    int fails = 0, checks_done = 0;
    always #20 clk_sys_i = ~clk_sys_i;
    lpc_host_model host (.clk_sys_i(clk_sys_i), .wr_o(wr), .rd_o(rd),
        .lock_o(lsel), .gpi_o(gsel), .idx_o(idx), .wdata_o(wdata));
    flash_block_lock uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .init_n_i(init_n_i), .lpc_mode_i(lpc_mode_i), .lock_sel_i(lsel),
        .gpi_sel_i(gsel), .lock_idx_i(idx), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_wdata_i(wdata), .reg_rdata_o(reg_rdata_o),
        .reg_rvalid_o(reg_rvalid_o), .arr_rd_i(arr_rd_i),
        .arr_rd_blk_i(arr_rd_blk_i), .arr_rdata_i(arr_rdata_i),
        .arr_rdata_o(arr_rdata_o), .arr_rvalid_o(arr_rvalid_o),
        .mod_req_i(mod_req_i), .mod_blk_i(mod_blk_i), .mod_go_o(mod_go_o),
        .mod_refused_o(mod_refused_o), .status_clr_i(status_clr_i),
        .blk_prot_status_o(st), .top_block_protect_n_i(top_block_protect_n),
        .write_protect_n_i(wp), .program_voltage_lockout_i(vl),
        .general_input_i(gpi));
    ////////////////////////////////////////////////////////////////////
    task chk(input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e)
        begin
            fails++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk
    task rdc(input logic g, input logic [5:0] i, input logic [7:0] e);
        host.xfer(1'b0, g, i, 8'h00);
        #1 chk(e, reg_rdata_o);
        chk(8'h01, {7'h00, reg_rvalid_o});
    endtask : rdc
    // expected go flag; refused is its inverse
    task md(input logic [5:0] b, input logic go);
        @(posedge clk_sys_i);
        mod_req_i <= 1'b1;
        mod_blk_i <= b;
        @(posedge clk_sys_i);
        mod_req_i <= 1'b0;
        #1 chk({6'h00, go, !go}, {6'h00, mod_go_o, mod_refused_o});
    endtask : md
    task ard(input logic [5:0] b, input logic [7:0] e);
        @(posedge clk_sys_i);
        arr_rd_i <= 1'b1;
        arr_rd_blk_i <= b;
        arr_rdata_i <= 8'hA5;
        @(posedge clk_sys_i);
        arr_rd_i <= 1'b0;
        arr_rdata_i <= 8'h5A;
        #1 chk(e, arr_rdata_o);
        chk(8'h01, {7'h00, arr_rvalid_o});
    endtask : ard
    // pins pass two sync stages before they count
    task pins(input logic t, input logic w, input logic v);
        @(posedge clk_sys_i);
        {top_block_protect_n, wp, vl} <= {t, w, v};
        repeat (3) @(posedge clk_sys_i);
    endtask : pins
    ////////////////////////////////////////////////////////////////////
    task t_reset;
        rdc(1'b0, 6'h00, 8'h01);
        rdc(1'b0, 6'h22, 8'h01);
        rdc(1'b1, 6'h00, 8'h16);
        host.xfer(1'b1, 1'b1, 6'h00, 8'hFF);
        rdc(1'b1, 6'h00, 8'h16);
        rdc(1'b0, 6'h00, 8'h01);
    endtask : t_reset
    task t_lock;
        host.xfer(1'b1, 1'b0, 6'h01, 8'hFC);
        rdc(1'b0, 6'h01, 8'h04);
        ard(6'h10, 8'h00);
        ard(6'h11, 8'hA5);
        md(6'h10, 1'b1);
        md(6'h11, 1'b0);
        chk(8'h01, {7'h00, st});
        @(posedge clk_sys_i);
        status_clr_i <= 1'b1;
        @(posedge clk_sys_i);
        status_clr_i <= 1'b0;
        #1 chk(8'h00, {7'h00, st});
    endtask : t_lock
    task t_pins;
        host.xfer(1'b1, 1'b0, 6'h00, 8'h00);
        host.xfer(1'b1, 1'b0, 6'h22, 8'h00);
        md(6'h00, 1'b1);
        md(6'h0F, 1'b1);
        pins(1'b1, 1'b0, 1'b0);
        md(6'h05, 1'b0);
        md(6'h31, 1'b1);
        pins(1'b0, 1'b1, 1'b0);
        md(6'h31, 1'b0);
        md(6'h00, 1'b1);
        pins(1'b1, 1'b1, 1'b1);
        md(6'h10, 1'b0);
        pins(1'b1, 1'b1, 1'b0);
    endtask : t_pins
    task t_down;
        host.xfer(1'b1, 1'b0, 6'h02, 8'h02);
        host.xfer(1'b1, 1'b0, 6'h02, 8'h04);
        rdc(1'b0, 6'h02, 8'h02);
        @(posedge clk_sys_i);
        lpc_mode_i <= 1'b0;
        host.xfer(1'b1, 1'b0, 6'h03, 8'h00);
        rdc(1'b0, 6'h03, 8'h00);
        @(posedge clk_sys_i);
        lpc_mode_i <= 1'b1;
        rdc(1'b0, 6'h03, 8'h01);
        @(posedge clk_sys_i);
        init_n_i <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        init_n_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        chk(8'h00, {7'h00, st});
        rdc(1'b0, 6'h02, 8'h01);
        rdc(1'b0, 6'h00, 8'h01);
    endtask : t_down
    task final_report;
        if (fails == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : final_report
    // watchdog far beyond the fewer than one hundred cycles of the run
    initial
    begin
        #100000;
        fails++;
        final_report();
    end
    initial
    begin
        repeat (4) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        t_reset();
        t_lock();
        t_pins();
        t_down();
        final_report();
    end
endmodule : flash_block_lock_tb
